//--- async_serial_transmitter_tb_top.sv
/* async_serial_transmitter_tb_top: self-checking bench for serial_tx.
   Assumes serial_rx_model on the line and the bound checker. */
`timescale 1ns/1ps
module async_serial_transmitter_tb_top
	import serial_tx_pkg::*;
;
	logic       SYS_CLK = 1'b0;
	logic       ARST_N, WR, RD, TXD_O, TXD_OE, TX_IRQ, IRQ, nine, watch, hi;
	logic [7:0] ADDR, WDATA, RDATA, s;
	logic [9:0] rx_word;
	logic [9:0] exp_q [$];
	int         rx_cnt, sent, errors, checks_done, bit_clks;
	integer     seed;
	logic [7:0] ra [7] = '{8'h13, 8'h14, 8'h16, 8'h17, 8'h18, 8'h1B, 8'h30};
	logic [7:0] rv [7] = '{8'h00, 8'h00, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00};

	serial_tx DUT (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .ADDR(ADDR),
		.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TXD_O(TXD_O),
		.TXD_OE(TXD_OE), .TX_IRQ(TX_IRQ), .IRQ(IRQ));
	// a released pin is pulled high at the far end
	serial_rx_model RX (.clk(SYS_CLK), .line(TXD_O | ~TXD_OE), .nine(nine),
		.bit_clks(bit_clks), .word(rx_word), .count(rx_cnt));
	always #2.5 SYS_CLK = ~SYS_CLK;
	// ********
	// bus and checking tasks
	// ********
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		ADDR <= a;
		WDATA <= d;
		WR <= 1'b1;
		@(posedge SYS_CLK);
		WR <= 1'b0;
		@(posedge SYS_CLK);
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		ADDR <= a;
		RD <= 1'b1;
		@(posedge SYS_CLK);
		RD <= 1'b0;
		@(posedge SYS_CLK);
		d = RDATA;
	endtask
	task automatic check(input string what, input logic [9:0] seen,
		input logic [9:0] exp);
		checks_done++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test;
		if (errors == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// wait for the buffer to free up, then queue one character
	task automatic send(input logic [7:0] d, input logic t8);
		s = 8'h00;
		for (int i = 0; i < 1000 && !s[S1_BUFFER_EMPTY]; i++) begin
			rd(ADDR_STATUS_ONE, s);
		end
		check("buffer_free", 10'(s[S1_BUFFER_EMPTY]), 10'd1);
		if (!s[S1_BUFFER_EMPTY]) stop_test;
		wr(ADDR_CONTROL_THREE, {1'b0, t8, 6'h00});
		rd(ADDR_STATUS_ONE, s);
		wr(ADDR_CHAR_BUFFER, d);
		exp_q.push_back(nine ? {1'b1, t8, d} : {2'b01, d});
		sent++;
	endtask
	task automatic drain;
		for (int i = 0; i < 4000 && rx_cnt < sent; i++) @(posedge SYS_CLK);
		check("frames_done", 10'(rx_cnt), 10'(sent));
		if (rx_cnt < sent) stop_test;
	endtask
	// every decoded frame is compared in order while watch is set
	always @(rx_cnt) begin
		if (watch) check("frame", rx_word, exp_q.pop_front());
	end
	// ********
	// main sequence
	// ********
	initial begin
		seed = 5;
		{ARST_N, WR, RD, nine, ADDR, WDATA} = '0;
		watch = 1'b1;
		hi = 1'b1;
		bit_clks = 16;
		repeat (16) @(posedge SYS_CLK);
		ARST_N <= 1'b1;
		repeat (3) @(posedge SYS_CLK);
		for (int k = 0; k < 7; k++) begin
			rd(ra[k], s);
			check("reset_read", 10'(s), 10'(rv[k]));
		end
		wr(ADDR_CONTROL_ONE, 8'h20);
		repeat (3) @(posedge SYS_CLK);
		check("idle_inverted", 10'(TXD_O), 10'd0);
		wr(ADDR_CONTROL_ONE, 8'h40);
		wr(ADDR_CONTROL_TWO, 8'h88);
		check("pin_owned", 10'(TXD_OE), 10'd1);
		check("idle_high", 10'(TXD_O), 10'd1);
		check("tx_irq_on", 10'(TX_IRQ), 10'd1);
		wr(ADDR_CONTROL_TWO, 8'h08);
		repeat (2) @(posedge SYS_CLK);
		check("tx_irq_off", 10'(TX_IRQ), 10'd0);
		wr(ADDR_CONTROL_TWO, 8'h88);
		for (int k = 0; k < 7; k++) begin
			if (k == 4) begin
				drain;
				wr(ADDR_CONTROL_ONE, 8'h50);
				wr(ADDR_BIT_RATE_SEL, 8'h01);
				nine = 1'b1;
				bit_clks = 32;
			end
			send(8'($random(seed)), 1'($random(seed)));
			if (k == 0) begin
				rd(ADDR_STATUS_ONE, s);
				check("empty_clear", 10'(s[S1_BUFFER_EMPTY]), 10'd0);
				check("tx_irq_low", 10'(TX_IRQ), 10'd0);
				for (int i = 0; i < 9 * bit_clks; i++) begin
					@(posedge SYS_CLK);
					hi = hi & TXD_O;
				end
				check("preamble", 10'(hi), 10'd1);
			end
		end
		drain;
		// let the last stop bit finish
		repeat (bit_clks) @(posedge SYS_CLK);
		rd(ADDR_BIT_RATE_SEL, s);
		check("rate_readback", 10'(s), 10'h001);
		wr(ADDR_IRQ_MASK, 8'h01);
		check("irq_raised", 10'(IRQ), 10'd1);
		wr(ADDR_IRQ_MASK, 8'h00);
		check("irq_masked", 10'(IRQ), 10'd0);
		wr(ADDR_IRQ_MASK, 8'h03);
		wr(ADDR_IRQ_STATUS, 8'h03);
		rd(ADDR_IRQ_STATUS, s);
		check("irq_cleared", 10'({s[1:0], IRQ}), 10'd0);
		// second prescale step: three base periods of 16 clocks per bit
		wr(ADDR_BIT_RATE_SEL, 8'h10);
		bit_clks = 48;
		send(8'h5A, 1'b0);
		drain;
		// queue one more back to back, then cut it part-way
		send(8'hA5, 1'b1);
		repeat (5 * bit_clks) @(posedge SYS_CLK);
		watch = 1'b0;
		wr(ADDR_CONTROL_ONE, 8'h00);
		// the enable is seen one edge after the write lands
		@(posedge SYS_CLK);
		check("pin_released", 10'(TXD_OE), 10'd0);
		check("line_idle_cut", 10'(TXD_O), 10'd1);
		stop_test;
	end
endmodule

//--- serial_rx_model.sv
/* serial_rx_model: behavioural far-end receiver of the serial line.
   Assumes a non-inverted line and a bit time given by the bench. */
`timescale 1ns/1ps
module serial_rx_model (
	input  wire logic       clk,
	input  wire logic       line,
	input  wire logic       nine,
	input  int              bit_clks,
	output logic      [9:0] word,
	output int              count
);
	// find a start bit, then sample every data and stop bit in its middle
	initial begin
		word = '0;
		count = 0;
		forever begin
			@(posedge clk);
			if (line === 1'b0) begin
				repeat (bit_clks / 2) @(posedge clk);
				word = '0;
				for (int i = 0; i <= 8 + nine; i++) begin
					repeat (bit_clks) @(posedge clk);
					word[i] = line; // lsb first, stop last
				end
				count++;
			end
		end
	end
endmodule

//--- serial_tx.sv
/*
 * Transmit half of an asynchronous serial port: registers, bit-rate
 * generator, preamble/frame shifter and interrupt logic.
 * Assumes a same-clock register master and one asynchronous reset.
 */
// Implementation choice: strobed register access.
// Overview of operation
// RULE1: a control_one bit picks 8 or 9 data bits per character.
// RULE2: in 9-bit mode the ninth bit comes from a control_three bit.
// RULE3: char_buffer is a write-only holding buffer ahead of the shifter.
// RULE4: software sets port enable, then transmitter enable, before use.
// RULE5: empty flag clears only on status read followed by buffer write.
// RULE6: a transmission opens with an all-high preamble character.
// RULE7: each frame gets a low start bit and a high stop bit.
// RULE8: the empty flag sets when the buffer hands over to the shifter.
// RULE9: an interrupt is raised while empty flag and its enable are set.
// RULE10: the output rests high whenever nothing is being shifted.
// RULE11: clearing port enable releases the shared pin at once.
// RULE12: transmit timing comes from the shared bit-rate generator.
// RULE13: frames use the mark/space non-return-to-zero format.
// RULE14: the bit-rate generator offers thirty-two selectable rates.
// RULE15: software can invert the polarity of the output.
// RULE16: the transmit interrupt has its own output line.
// RULE17: data goes out lsb first, one bit period each, stop bit last.
`timescale 1ns/1ps

module serial_tx
	import serial_tx_pkg::*;
(
	input  wire logic       SYS_CLK,
	input  wire logic       ARST_N,
	input  wire logic [7:0] ADDR,
	input  wire logic [7:0] WDATA,
	input  wire logic       WR,
	input  wire logic       RD,
	output logic      [7:0] RDATA,
	output logic            TXD_O,
	output logic            TXD_OE,
	output logic            TX_IRQ,
	output logic            IRQ
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic       rst_meta_ff;
	logic       rst_n_ff;
	reg_req_t   req;
	tx_regs_t   st_ff;
	tx_regs_t   nxt_st;

	// two-stage release of the asynchronous reset
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// bundle the register request
	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// ****************************************************************
	// helpers
	// ****************************************************************
	// prescaler terminal value from the two prescale select bits
	function automatic logic [15:0] pre_limit(input logic [1:0] sel);
		case (sel)
			2'd0:    pre_limit = 16'h0000;
			2'd1:    pre_limit = 16'h0002;
			2'd2:    pre_limit = 16'h0003;
			default: pre_limit = 16'h000C;
		endcase
	endfunction

	// rate divider terminal value, 2^sel base ticks per bit
	function automatic logic [7:0] rate_limit(input logic [2:0] sel);
		rate_limit = 8'((16'h0001 << sel) - 16'h0001);
	endfunction

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		logic        en;
		logic        txe;
		logic        nine;
		logic        base_tick;
		logic [15:0] pre_top;
		logic [7:0]  rate_top;
		logic [3:0]  frame_len;
		logic        set_empty;
		logic        clr_empty;
		logic [1:0]  irq_set;
		en        = 1'b0;
		txe       = 1'b0;
		nine      = 1'b0;
		base_tick = 1'b0;
		pre_top   = 16'h0000;
		rate_top  = 8'h00;
		frame_len = 4'h0;
		set_empty = 1'b0;
		clr_empty = 1'b0;
		irq_set   = 2'h0;
		nxt_st    = st_ff;

		en   = st_ff.control_one[C1_PORT_ENABLE];
		txe  = st_ff.control_two[C2_TX_ENABLE];           // RULE4
		nine = st_ff.control_one[C1_NINE_BIT];            // RULE1
		frame_len = nine ? SHIFT_W9 : SHIFT_W8;

		// register writes
		if (req.wr) begin
			case (req.addr)
				ADDR_CONTROL_ONE:   nxt_st.control_one = req.wdata;
				ADDR_CONTROL_TWO:   nxt_st.control_two = req.wdata;
				ADDR_CONTROL_THREE: nxt_st.control_three =
					req.wdata & C3_WR_MASK;
				ADDR_BIT_RATE_SEL:  nxt_st.bit_rate_select =
					req.wdata & BR_WR_MASK;
				ADDR_CHAR_BUFFER: begin
					nxt_st.char_buffer = req.wdata;            // RULE3
					clr_empty = st_ff.status_read_armed;       // RULE5
				end
				ADDR_IRQ_MASK:      nxt_st.irq_mask = req.wdata[1:0];
				default: ;
			endcase
		end

		// status read arms the flag clear, the next buffer write uses it
		if (req.rd && req.addr == ADDR_STATUS_ONE && st_ff.buffer_empty)
			nxt_st.status_read_armed = 1'b1;              // RULE5
		else if (req.wr && req.addr == ADDR_CHAR_BUFFER)
			nxt_st.status_read_armed = 1'b0;

		// read data, answered in the following cycle
		nxt_st.rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				ADDR_CONTROL_ONE:   nxt_st.rdata = st_ff.control_one;
				ADDR_CONTROL_TWO:   nxt_st.rdata = st_ff.control_two;
				ADDR_CONTROL_THREE: nxt_st.rdata = st_ff.control_three;
				ADDR_STATUS_ONE: begin
					nxt_st.rdata[S1_BUFFER_EMPTY] = st_ff.buffer_empty;
					nxt_st.rdata[S1_TX_COMPLETE]  =
						st_ff.buffer_empty && st_ff.state == ST_IDLE;
				end
				ADDR_BIT_RATE_SEL:  nxt_st.rdata = st_ff.bit_rate_select;
				ADDR_IRQ_STATUS:    nxt_st.rdata = {6'h00, st_ff.irq_status};
				ADDR_IRQ_MASK:      nxt_st.rdata = {6'h00, st_ff.irq_mask};
				default:            nxt_st.rdata = 8'h00; // write-only or unmapped
			endcase
		end

		// shared bit-rate generator: 4 prescales x 8 dividers
		pre_top  = pre_limit(st_ff.bit_rate_select[5:4]);     // RULE14
		rate_top = rate_limit(st_ff.bit_rate_select[2:0]);    // RULE14
		nxt_st.bit_tick = 1'b0;
		if (!en) begin
			nxt_st.prescale = 16'h0000;
			nxt_st.rate_cnt = 8'h00;
		end else if (st_ff.prescale >=
			16'((pre_top + 16'h0001) * 16'(BASE_DIV) - 16'h0001)) begin
			nxt_st.prescale = 16'h0000;
			base_tick = 1'b1;
		end else begin
			nxt_st.prescale = st_ff.prescale + 16'h0001;
		end
		if (base_tick) begin
			if (st_ff.rate_cnt >= rate_top) begin
				nxt_st.rate_cnt = 8'h00;
				nxt_st.bit_tick = 1'b1;                       // RULE12
			end else begin
				nxt_st.rate_cnt = st_ff.rate_cnt + 8'h01;
			end
		end

		// transmit sequencer
		case (st_ff.state)
			ST_IDLE: begin
				nxt_st.line = 1'b1;                           // RULE10
				if (en && txe && !st_ff.buffer_empty) begin
					nxt_st.state   = ST_PREAMBLE;             // RULE6
					nxt_st.bit_cnt = frame_len + 4'h1;
					nxt_st.shifter = '1;
				end
			end
			ST_PREAMBLE: begin
				nxt_st.line = 1'b1;                           // RULE6
				if (st_ff.bit_tick) begin
					if (st_ff.bit_cnt == 4'h0) begin
						// load {stop, ninth, data, start}
						nxt_st.shifter = {1'b1,
							nine ? st_ff.control_three[C3_TX_NINTH_BIT]
							     : 1'b1,
							st_ff.char_buffer, 1'b0};             // RULE7 RULE2
						if (!nine)
							nxt_st.shifter[9] = 1'b1;
						set_empty = 1'b1;                         // RULE8
						nxt_st.bit_cnt = frame_len;
						nxt_st.state   = ST_SHIFT;
						nxt_st.line    = 1'b0;
					end else begin
						nxt_st.bit_cnt = st_ff.bit_cnt - 4'h1;
					end
				end
			end
			ST_SHIFT: begin
				if (st_ff.bit_tick) begin
					nxt_st.shifter = {1'b1, st_ff.shifter[10:1]}; // RULE17
					nxt_st.line    = st_ff.shifter[1];            // RULE13
					if (st_ff.bit_cnt == 4'h0) begin
						// stop bit has served its period
						if (en && txe && !st_ff.buffer_empty) begin
							nxt_st.shifter = {1'b1,
								nine ? st_ff.control_three[C3_TX_NINTH_BIT]
								     : 1'b1,
								st_ff.char_buffer, 1'b0};         // RULE7 RULE2
							set_empty = 1'b1;                     // RULE8
							nxt_st.bit_cnt = frame_len;
							nxt_st.line    = 1'b0;
						end else begin
							nxt_st.state = ST_IDLE;
							nxt_st.line  = 1'b1;                  // RULE10
						end
					end else begin
						nxt_st.bit_cnt = st_ff.bit_cnt - 4'h1;
					end
				end
			end
			default: nxt_st.state = ST_IDLE;
		endcase

		// port enable low drops the frame and releases the pin
		if (!en) begin
			nxt_st.state = ST_IDLE;                           // RULE11
			nxt_st.line  = 1'b1;
		end
		nxt_st.pin_oe = en;                                   // RULE11

		// empty flag: hardware set wins over the software clear
		if (set_empty)
			nxt_st.buffer_empty = 1'b1;                       // RULE8
		else if (clr_empty)
			nxt_st.buffer_empty = 1'b0;                       // RULE5

		// sticky event bits, write one to clear, set wins
		irq_set[IRQ_BIT_EMPTY] = set_empty;
		irq_set[IRQ_BIT_DONE]  = st_ff.state == ST_SHIFT &&
			nxt_st.state == ST_IDLE;
		if (req.wr && req.addr == ADDR_IRQ_STATUS)
			nxt_st.irq_status = st_ff.irq_status & ~req.wdata[1:0];
		nxt_st.irq_status = nxt_st.irq_status | irq_set;
		nxt_st.irq = |(nxt_st.irq_status & nxt_st.irq_mask & IRQ_MASK_W);

		// transmit request, separate from any receive request
		nxt_st.tx_irq = nxt_st.buffer_empty &&
			nxt_st.control_two[C2_EMPTY_IRQ_EN];              // RULE9 RULE16
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			st_ff <= '{
				control_one:       RST_CONTROL,
				control_two:       RST_CONTROL,
				control_three:     RST_CONTROL,
				bit_rate_select:   RST_CONTROL,
				char_buffer:       8'h00,
				buffer_empty:      1'b1,
				status_read_armed: 1'b0,
				irq_status:        2'h0,
				irq_mask:          2'h0,
				rdata:             8'h00,
				prescale:          16'h0000,
				rate_cnt:          8'h00,
				bit_tick:          1'b0,
				bit_cnt:           4'h0,
				shifter:           '1,
				state:             ST_IDLE,
				line:              1'b1,
				pin_oe:            1'b0,
				irq:               1'b0,
				tx_irq:            1'b0
			};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ****************************************************************
	// outputs, TXD_O from its own flop, the rest straight from the state register
	// ****************************************************************
	logic txd_ff;

	// polarity select applied in its own flop
	always_ff @(posedge SYS_CLK or negedge rst_n_ff) begin
		if (!rst_n_ff)
			txd_ff <= 1'b1;
		else
			txd_ff <= nxt_st.line ^ nxt_st.control_one[C1_TX_INVERT]; // RULE15
	end

	assign RDATA  = st_ff.rdata;
	assign TXD_O  = txd_ff;
	assign TXD_OE = st_ff.pin_oe;
	assign TX_IRQ = st_ff.tx_irq;
	assign IRQ    = st_ff.irq;

endmodule

//--- serial_tx_checker.sv
/* serial_tx_checker: port-level assertions for serial_tx.
   Assumes a bind onto serial_tx and a single clock domain. */
`timescale 1ns/1ps
module serial_tx_checker
	import serial_tx_pkg::*;
(
	input wire logic       SYS_CLK,
	input wire logic       ARST_N,
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic       WR,
	input wire logic       RD,
	input wire logic [7:0] RDATA,
	input wire logic       TXD_O,
	input wire logic       TXD_OE,
	input wire logic       TX_IRQ,
	input wire logic       IRQ
);
	logic       wr_c1, wr_c2;
	logic       ie_ff, inv_ff, te_ff, seen_ff, rds_ff;
	logic [1:0] msk_ff;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);
	// ********
	// shadows of software writes and status reads
	// ********
	assign wr_c1 = WR && ADDR == ADDR_CONTROL_ONE;
	assign wr_c2 = WR && ADDR == ADDR_CONTROL_TWO;
	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			{ie_ff, inv_ff, te_ff, seen_ff, rds_ff, msk_ff} <= '0;
		end else begin
			rds_ff <= RD && ADDR == ADDR_STATUS_ONE;
			if (wr_c1) inv_ff <= WDATA[C1_TX_INVERT];
			if (wr_c2) ie_ff <= WDATA[C2_EMPTY_IRQ_EN];
			te_ff <= te_ff | (wr_c2 & WDATA[C2_TX_ENABLE]);
			if (WR && ADDR == ADDR_IRQ_MASK) msk_ff <= WDATA[1:0];
			if (WR && ADDR == ADDR_CHAR_BUFFER) seen_ff <= 1'b0;
			else if (rds_ff && RDATA[S1_BUFFER_EMPTY]) seen_ff <= 1'b1;
		end
	end
	// ********
	// assertions
	// ********
	AST_OE_ON: assert property (
		wr_c1 && WDATA[C1_PORT_ENABLE] |-> ##[1:2] TXD_OE)
		else $error("pin not taken after enable");
	AST_OE_OFF: assert property (
		wr_c1 && !WDATA[C1_PORT_ENABLE] |=> ##1 !TXD_OE)
		else $error("pin kept after disable");
	AST_RD_IDLE: assert property (
		!$past(RD) |-> RDATA == 8'h00)
		else $error("read data outside read slot");
	AST_WO_READ: assert property (
		RD && ADDR == ADDR_CHAR_BUFFER |=> RDATA == 8'h00)
		else $error("holding buffer readable");
	AST_TXIRQ_OFF: assert property (
		!ie_ff && !$past(ie_ff) |-> !TX_IRQ)
		else $error("tx irq without enable");
	AST_IRQ_MASKED: assert property (
		msk_ff == 2'h0 && $past(msk_ff) == 2'h0 |-> !IRQ)
		else $error("irq with all masked");
	AST_IDLE_LEVEL: assert property (
		!te_ff && $stable(inv_ff) && inv_ff == $past(inv_ff, 2)
		|-> TXD_O == !inv_ff)
		else $error("line off idle level");
	AST_EMPTY_STICKY: assert property (
		rds_ff && seen_ff |-> RDATA[S1_BUFFER_EMPTY])
		else $error("empty flag cleared without write");
	COV_FRAME: cover property (TXD_OE && $fell(TXD_O));
	COV_TXIRQ: cover property ($rose(TX_IRQ));
	COV_IRQ: cover property ($rose(IRQ));
endmodule

bind serial_tx serial_tx_checker chk (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
	.ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.TXD_O(TXD_O), .TXD_OE(TXD_OE), .TX_IRQ(TX_IRQ), .IRQ(IRQ));

//--- serial_tx_pkg.sv
/*
 * Constants, register map and carrier types for the serial transmitter.
 * Assumes a byte-wide register port and a single 200 MHz clock.
 */
package serial_tx_pkg;

	// ****************************************************************
	// register map
	// ****************************************************************
	localparam logic [7:0] ADDR_CONTROL_ONE   = 8'h13;
	localparam logic [7:0] ADDR_CONTROL_TWO   = 8'h14;
	localparam logic [7:0] ADDR_CONTROL_THREE = 8'h15;
	localparam logic [7:0] ADDR_STATUS_ONE    = 8'h16;
	localparam logic [7:0] ADDR_STATUS_TWO    = 8'h17;
	localparam logic [7:0] ADDR_CHAR_BUFFER   = 8'h18;
	localparam logic [7:0] ADDR_BIT_RATE_SEL  = 8'h19;
	localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h1A;
	localparam logic [7:0] ADDR_IRQ_MASK      = 8'h1B;

	// ****************************************************************
	// field positions
	// ****************************************************************
	localparam int C1_PORT_ENABLE   = 6;
	localparam int C1_TX_INVERT     = 5;
	localparam int C1_NINE_BIT      = 4;
	localparam int C2_EMPTY_IRQ_EN  = 7;
	localparam int C2_TX_ENABLE     = 3;
	localparam int C3_TX_NINTH_BIT  = 6;
	localparam int S1_BUFFER_EMPTY  = 7;
	localparam int S1_TX_COMPLETE   = 6;
	localparam int IRQ_BIT_EMPTY    = 0;
	localparam int IRQ_BIT_DONE     = 1;

	// ****************************************************************
	// reset values and masks
	// ****************************************************************
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [7:0] C3_WR_MASK  = 8'h4F;
	localparam logic [7:0] BR_WR_MASK  = 8'h37;
	localparam logic [1:0] IRQ_MASK_W  = 2'h3;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ       = 200;
	localparam int BASE_DIV      = 16;   // clocks per base period; pre_limit + 1 periods per base tick
	localparam int FRAME_MAX     = 11;   // start, nine data, stop
	localparam logic [3:0] SHIFT_W8  = 4'h9;  // start + 8 data
	localparam logic [3:0] SHIFT_W9  = 4'hA;  // start + 9 data

	typedef enum {ST_IDLE, ST_PREAMBLE, ST_SHIFT} tx_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic [7:0]  control_one;
		logic [7:0]  control_two;
		logic [7:0]  control_three;
		logic [7:0]  bit_rate_select;
		logic [7:0]  char_buffer;
		logic        buffer_empty;
		logic        status_read_armed;
		logic [1:0]  irq_status;
		logic [1:0]  irq_mask;
		logic [7:0]  rdata;
		logic [15:0] prescale;
		logic [7:0]  rate_cnt;
		logic        bit_tick;
		logic [3:0]  bit_cnt;
		logic [10:0] shifter;
		tx_state_t   state;
		logic        line;
		logic        pin_oe;
		logic        irq;
		logic        tx_irq;
	} tx_regs_t;

endpackage
